// ===== hdl/pio_params.svh
// Constants for the parallel I/O port block
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

`define PIO_ADDR_PORT_A_DATA 16'h1000
`define PIO_ADDR_PARALLEL_IO_CONTROL 16'h1002
`define PIO_ADDR_PORT_C_DATA 16'h1003
`define PIO_ADDR_PORT_B_DATA 16'h1004
`define PIO_ADDR_PORT_C_STROBE_LATCH 16'h1005
`define PIO_ADDR_PORT_C_DIRECTION 16'h1007
`define PIO_ADDR_PORT_D_DATA 16'h1008
`define PIO_ADDR_PORT_D_DIRECTION 16'h1009
`define PIO_ADDR_PORT_E_INPUTS 16'h100A
`define PIO_ADDR_PULSE_ACCUM_CONTROL 16'h1026
`define PIO_ADDR_PORT_G_DATA 16'h1036
`define PIO_ADDR_PORT_G_DIRECTION 16'h1037

`define PIO_RST_BYTE 8'h00
`define PIO_RST_PCTL 8'h00
`define PIO_PA_IN_MASK 8'h07
`define PIO_PA_OUT_MASK 8'h70
`define PIO_PD_MASK 8'h3F
`define PIO_BIT_PIN3_DIR 3
`define PIO_BIT_PIN7_DIR 7
`define PIO_BIT_STAF 7
`define PIO_BIT_CWOM 5
`define PIO_BIT_EDGE_SEL 1
`define PIO_BIT_STBB_POL 0
`define PIO_BIT_SS 5
`define PIO_STBB_CYCLES 2'h2

`endif

// ===== hdl/pio_pkg.sv
// Types shared by the parallel I/O port block
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_MODE_SINGLE,
    PIO_MODE_EXPANDED,
    PIO_MODE_BOOT,
    PIO_MODE_TEST
  } pio_mode_e;
  typedef logic [7:0] pio_byte_t;
endpackage : pio_pkg

// ===== hdl/pio_sync.sv
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module pio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : pio_sync

// ===== hdl/pio_ports.sv
// Parallel I/O ports with register access, strobes and pin overrides
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_ports
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic ext_access_o,
  // Operating mode
  input wire pio_mode_e mode_i,
  // First port and timer overrides
  input wire logic [7:0] pa_in_i,
  output logic [7:0] pa_out_o,
  output logic [7:0] pa_oe_o,
  input wire logic [7:0] timer_oc_en_i,
  input wire logic [7:0] timer_oc_val_i,
  // Second port
  input wire logic [7:0] addr_hi_i,
  output logic [7:0] pb_out_o,
  output logic strobe_b_o,
  // Third port and strobe A
  input wire logic [7:0] pc_in_i,
  output logic [7:0] pc_out_o,
  output logic [7:0] pc_oe_o,
  input wire logic [7:0] ext_ad_i,
  input wire logic ext_ad_oe_i,
  input wire logic strobe_a_i,
  // Fourth port and serial overrides
  input wire logic [5:0] pd_in_i,
  output logic [5:0] pd_out_o,
  output logic [5:0] pd_oe_o,
  input wire logic [5:0] serial_en_i,
  input wire logic [5:0] serial_out_i,
  input wire logic [5:0] serial_oe_i,
  input wire logic spi_master_select_i,
  output logic mode_fault_en_o,
  // Fifth port
  input wire logic [7:0] pe_in_i,
  // Sixth port
  input wire logic [7:0] pg_in_i,
  output logic [7:0] pg_out_o,
  output logic [7:0] pg_oe_o
);

  // Output register where driven, pin level where input
  function automatic pio_byte_t read_mix(
    input pio_byte_t dir,
    input pio_byte_t drv,
    input pio_byte_t pin
  );
    read_mix = (dir & drv) | (~dir & pin);
  endfunction : read_mix

  // Registers
  pio_byte_t pa_q;
  pio_byte_t pb_q;
  pio_byte_t pc_q;
  pio_byte_t pc_dir_q;
  pio_byte_t pc_latch_q;
  pio_byte_t pctl_q;
  pio_byte_t pacc_q;
  pio_byte_t pg_q;
  pio_byte_t pg_dir_q;
  logic [5:0] pd_q;
  logic [5:0] pd_dir_q;
  logic staf_q;
  logic staf_armed_q;
  logic stba_prev_q;
  logic [1:0] stbb_cnt_q;
  pio_byte_t rdata_q;
  logic ext_q;

  // Synchronised pins
  logic stba_s;
  pio_byte_t pa_s;
  pio_byte_t pc_s;
  logic [5:0] pd_s;
  pio_byte_t pe_s;
  pio_byte_t pg_s;

  pio_sync #(
    .W(39)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({strobe_a_i, pa_in_i, pc_in_i, pd_in_i, pe_in_i, pg_in_i}),
    .q_o({stba_s, pa_s, pc_s, pd_s, pe_s, pg_s})
  );

  // Mode decode
  wire single_w = (mode_i == PIO_MODE_SINGLE) || (mode_i == PIO_MODE_BOOT);
  wire pc_ext_w = !single_w;

  // Write and read selects
  wire wr_pa_w = wr_i && (addr_i == `PIO_ADDR_PORT_A_DATA);
  wire wr_pctl_w = wr_i && (addr_i == `PIO_ADDR_PARALLEL_IO_CONTROL);
  wire acc_pc_w = (wr_i || rd_i) && (addr_i == `PIO_ADDR_PORT_C_DATA);
  wire wr_pc_w = wr_i && (addr_i == `PIO_ADDR_PORT_C_DATA) && single_w;
  wire wr_pb_w = wr_i && (addr_i == `PIO_ADDR_PORT_B_DATA);
  wire wr_pcl_w = wr_i && (addr_i == `PIO_ADDR_PORT_C_STROBE_LATCH);
  wire wr_pcd_w = wr_i && (addr_i == `PIO_ADDR_PORT_C_DIRECTION);
  wire wr_pd_w = wr_i && (addr_i == `PIO_ADDR_PORT_D_DATA);
  wire wr_pdd_w = wr_i && (addr_i == `PIO_ADDR_PORT_D_DIRECTION);
  wire wr_pacc_w = wr_i && (addr_i == `PIO_ADDR_PULSE_ACCUM_CONTROL);
  wire wr_pg_w = wr_i && (addr_i == `PIO_ADDR_PORT_G_DATA);
  wire wr_pgd_w = wr_i && (addr_i == `PIO_ADDR_PORT_G_DIRECTION);
  wire rd_pctl_w = rd_i && (addr_i == `PIO_ADDR_PARALLEL_IO_CONTROL);
  wire rd_pcl_w = rd_i && (addr_i == `PIO_ADDR_PORT_C_STROBE_LATCH);

  // Strobe A edge detection
  wire edge_sel_w = pctl_q[`PIO_BIT_EDGE_SEL];
  wire stba_rise_w = stba_s && !stba_prev_q;
  wire stba_fall_w = !stba_s && stba_prev_q;
  wire stba_edge_w = edge_sel_w ? stba_rise_w : stba_fall_w;

  // First port drive
  wire [7:0] pa_bidir_w = {pacc_q[`PIO_BIT_PIN7_DIR], 3'h0,
                           pacc_q[`PIO_BIT_PIN3_DIR], 3'h0};
  wire [7:0] pa_oc_w = timer_oc_en_i & ~`PIO_PA_IN_MASK;
  assign pa_oe_o = (`PIO_PA_OUT_MASK | pa_bidir_w | pa_oc_w)
                   & ~`PIO_PA_IN_MASK;
  assign pa_out_o = (pa_oc_w & timer_oc_val_i) | (~pa_oc_w & pa_q);

  // Second port: data or high address
  assign pb_out_o = single_w ? pb_q : addr_hi_i;
  wire stbb_active_w = (stbb_cnt_q != 2'h0);
  assign strobe_b_o = stbb_active_w ~^ pctl_q[`PIO_BIT_STBB_POL];

  // Third port: GPIO or multiplexed bus
  wire cwom_w = pctl_q[`PIO_BIT_CWOM];
  wire [7:0] pc_gp_oe_w = cwom_w ? (pc_dir_q & ~pc_q) : pc_dir_q;
  assign pc_out_o = pc_ext_w ? ext_ad_i : pc_q;
  assign pc_oe_o = pc_ext_w ? {8{ext_ad_oe_i}} : pc_gp_oe_w;

  // Fourth port: GPIO or serial functions
  wire ss_gpio_w = pd_dir_q[`PIO_BIT_SS] && spi_master_select_i;
  wire [5:0] pd_ser_w = serial_en_i
                        & ~{ss_gpio_w, 5'h00};
  assign pd_out_o = (pd_ser_w & serial_out_i) | (~pd_ser_w & pd_q);
  assign pd_oe_o = (pd_ser_w & serial_oe_i) | (~pd_ser_w & pd_dir_q);
  assign mode_fault_en_o = !ss_gpio_w;

  // Sixth port
  assign pg_out_o = pg_q;
  assign pg_oe_o = pg_dir_q;

  assign rdata_o = rdata_q;
  assign ext_access_o = ext_q;

  // Read data mux
  pio_byte_t rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (addr_i == `PIO_ADDR_PORT_A_DATA)
      rd_mux = read_mix(pa_oe_o, pa_out_o, pa_s);
    else if (addr_i == `PIO_ADDR_PARALLEL_IO_CONTROL)
      rd_mux = {staf_q, pctl_q[6:0]};
    else if (addr_i == `PIO_ADDR_PORT_C_DATA && single_w)
      rd_mux = read_mix(pc_dir_q, pc_q, pc_s);
    else if (addr_i == `PIO_ADDR_PORT_B_DATA)
      rd_mux = pb_q;
    else if (addr_i == `PIO_ADDR_PORT_C_STROBE_LATCH)
      rd_mux = pc_latch_q;
    else if (addr_i == `PIO_ADDR_PORT_C_DIRECTION)
      rd_mux = pc_dir_q;
    else if (addr_i == `PIO_ADDR_PORT_D_DATA)
      rd_mux = read_mix({2'h0, pd_dir_q}, {2'h0, pd_q},
                        {2'h0, pd_s});
    else if (addr_i == `PIO_ADDR_PORT_D_DIRECTION)
      rd_mux = {2'h0, pd_dir_q};
    else if (addr_i == `PIO_ADDR_PORT_E_INPUTS)
      rd_mux = pe_s;
    else if (addr_i == `PIO_ADDR_PULSE_ACCUM_CONTROL)
      rd_mux = pacc_q;
    else if (addr_i == `PIO_ADDR_PORT_G_DATA)
      rd_mux = read_mix(pg_dir_q, pg_q, pg_s);
    else if (addr_i == `PIO_ADDR_PORT_G_DIRECTION)
      rd_mux = pg_dir_q;
  end

  // Bus answer, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_q <= 8'h00;
      ext_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_i ? rd_mux : 8'h00;
      ext_q <= acc_pc_w && pc_ext_w;
    end
  end

  // Third port data and direction
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pc_q <= `PIO_RST_BYTE;
      pc_dir_q <= `PIO_RST_BYTE;
    end
    else
    begin
      if (wr_pc_w || wr_pcl_w)
        pc_q <= wdata_i;
      if (wr_pcd_w)
        pc_dir_q <= wdata_i;
    end
  end

  // Strobe latch, written or captured on strobe A
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      pc_latch_q <= `PIO_RST_BYTE;
    else if (stba_edge_w)
      pc_latch_q <= pc_s;
    else if (wr_pcl_w)
      pc_latch_q <= wdata_i;
  end

  // Strobe A flag; a new edge wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      stba_prev_q <= 1'b0;
      staf_q <= 1'b0;
      staf_armed_q <= 1'b0;
    end
    else
    begin
      stba_prev_q <= stba_s;
      if (stba_edge_w)
        staf_q <= 1'b1;
      else if (staf_armed_q && rd_pcl_w)
        staf_q <= 1'b0;
      if (rd_pctl_w)
        staf_armed_q <= staf_q;
      else if (rd_pcl_w)
        staf_armed_q <= 1'b0;
    end
  end

  // Strobe B pulse counter
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      stbb_cnt_q <= 2'h0;
    else if (wr_pb_w && single_w)
      stbb_cnt_q <= `PIO_STBB_CYCLES;
    else if (stbb_active_w)
      stbb_cnt_q <= stbb_cnt_q - 2'h1;
  end

  // Remaining port registers
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pa_q <= `PIO_RST_BYTE;
      pb_q <= `PIO_RST_BYTE;
      pctl_q <= `PIO_RST_PCTL;
      pacc_q <= `PIO_RST_BYTE;
      pd_q <= 6'h00;
      pd_dir_q <= 6'h00;
      pg_q <= `PIO_RST_BYTE;
      pg_dir_q <= `PIO_RST_BYTE;
    end
    else
    begin
      if (wr_pa_w)
        pa_q <= wdata_i;
      if (wr_pb_w)
        pb_q <= wdata_i;
      if (wr_pctl_w)
        pctl_q <= {1'b0, wdata_i[6:0]};
      if (wr_pacc_w)
        pacc_q <= wdata_i;
      if (wr_pd_w)
        pd_q <= wdata_i[5:0];
      if (wr_pdd_w)
        pd_dir_q <= wdata_i[5:0];
      if (wr_pg_w)
        pg_q <= wdata_i;
      if (wr_pgd_w)
        pg_dir_q <= wdata_i;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking

  a_dir_reset: assert property (
    !resetn_i |=> pc_dir_q == 8'h00 && pd_dir_q == 6'h00
                  && pg_dir_q == 8'h00 && pc_q == 8'h00)
    else $error("directions or port data not cleared by reset");

  a_stbb_two_cycles: assert property (
    disable iff (!resetn_i)
    wr_pb_w && single_w |=>
      (strobe_b_o == pctl_q[`PIO_BIT_STBB_POL])[*2] ##1
      ($past(wr_pb_w) || $past(wr_pb_w, 2)
       || strobe_b_o != pctl_q[`PIO_BIT_STBB_POL]))
    else $error("strobe B pulse not two cycles");

  a_latch_capture: assert property (
    disable iff (!resetn_i)
    stba_edge_w |=> pc_latch_q == $past(pc_s) && staf_q)
    else $error("strobe A edge did not capture pins");

  a_edge_select: assert property (
    disable iff (!resetn_i)
    stba_rise_w && !edge_sel_w && !staf_q && !rd_pcl_w |=> !staf_q)
    else $error("wrong strobe A edge set the flag");

  a_ext_access: assert property (
    disable iff (!resetn_i)
    acc_pc_w && pc_ext_w |=> ext_access_o && $stable(pc_q)
                              && rdata_o == 8'h00)
    else $error("expanded third port access not passed out");

  a_latch_write: assert property (
    disable iff (!resetn_i)
    wr_pcl_w |=> pc_q == $past(wdata_i))
    else $error("latch write did not reach third port");

  a_pd_upper_zero: assert property (
    disable iff (!resetn_i)
    rd_i && addr_i == `PIO_ADDR_PORT_D_DIRECTION |=>
      rdata_o[7:6] == 2'h0 && rdata_o[5:0] == pd_dir_q)
    else $error("fourth port upper bits not zero");

  a_ss_gpio: assert property (
    disable iff (!resetn_i)
    pd_dir_q[5] && spi_master_select_i |->
      !mode_fault_en_o && pd_oe_o[5] && pd_out_o[5] == pd_q[5])
    else $error("slave-select not a plain output");

  a_pin3_override: assert property (
    disable iff (!resetn_i)
    timer_oc_en_i[3] |-> pa_oe_o[3] && pa_out_o[3] == timer_oc_val_i[3])
    else $error("output compare did not override pin 3");

  a_pg_read: assert property (
    disable iff (!resetn_i)
    rd_i && addr_i == `PIO_ADDR_PORT_G_DATA && !wr_i |=>
      rdata_o == ((pg_dir_q & pg_q) | (~pg_dir_q & $past(pg_s))))
    else $error("sixth port read mix wrong");

  a_pb_write: assert property (
    disable iff (!resetn_i)
    wr_pb_w && single_w |=> pb_out_o == $past(wdata_i)
                             || !single_w)
    else $error("second port write not on pins");

endmodule : pio_ports

// ===== testbench/pio_pin_model.sv
// Outside circuit loading a bidirectional port
`timescale 1ns/1ps
module pio_pin_model (
  // Port side
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  // Outside drive
  input wire logic [7:0] drive_i,
  output logic [7:0] pin_o
);
  // Driven bits show the port, the rest the outside circuit
  assign pin_o = (out_i & oe_i) | (drive_i & ~oe_i);
endmodule : pio_pin_model

// ===== testbench/tb_top.sv
// Self-checking bench for the parallel I/O ports
`timescale 1ns/1ps
module tb_top
  import pio_pkg::*;
;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} pio_row_s;
  logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, ext_ad_oe = 0;
  logic strobe_a = 1, spi_m = 0, ext_access_o, strobe_b_o, mode_fault_en_o;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o, got, oc_en = 8'h00, oc_val = 8'h00;
  logic [7:0] pa_in = 8'h00, pa_out, pa_oe, addr_hi = 8'h00, pb_out;
  logic [7:0] pc_drv = 8'h00, pc_pin, pc_out, pc_oe, ext_ad = 8'h00;
  logic [7:0] pe_in = 8'h00, pg_drv = 8'h00, pg_pin, pg_out, pg_oe;
  logic [5:0] pd_in = 6'h00, pd_out, pd_oe;
  logic [5:0] ser_en = 6'h00, ser_out = 6'h00, ser_oe = 6'h00;
  pio_mode_e mode = PIO_MODE_SINGLE;
  int n_errors = 0, n_checks = 0, cyc = 0;
  pio_row_s rows [9] = '{'{16'h1000, 8'hFF, 8'h70},
    '{16'h1007, 8'hFF, 8'hFF},
    '{16'h1003, 8'h3C, 8'h3C}, '{16'h1004, 8'h5A, 8'h5A},
    '{16'h1009, 8'hFF, 8'h3F}, '{16'h1037, 8'hFF, 8'hFF},
    '{16'h1036, 8'hA5, 8'hA5}, '{16'h1026, 8'h88, 8'h88},
    '{16'h1010, 8'hFF, 8'h00}};

  always #50 clk_i = ~clk_i;

  pio_ports uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_access_o(ext_access_o), .mode_i(mode), .pa_in_i(pa_in),
    .pa_out_o(pa_out), .pa_oe_o(pa_oe), .timer_oc_en_i(oc_en),
    .timer_oc_val_i(oc_val), .addr_hi_i(addr_hi), .pb_out_o(pb_out),
    .strobe_b_o(strobe_b_o), .pc_in_i(pc_pin), .pc_out_o(pc_out),
    .pc_oe_o(pc_oe), .ext_ad_i(ext_ad), .ext_ad_oe_i(ext_ad_oe),
    .strobe_a_i(strobe_a), .pd_in_i(pd_in), .pd_out_o(pd_out),
    .pd_oe_o(pd_oe), .serial_en_i(ser_en), .serial_out_i(ser_out),
    .serial_oe_i(ser_oe), .spi_master_select_i(spi_m),
    .mode_fault_en_o(mode_fault_en_o), .pe_in_i(pe_in), .pg_in_i(pg_pin),
    .pg_out_o(pg_out), .pg_oe_o(pg_oe));

  pio_pin_model pc_load (.out_i(pc_out), .oe_i(pc_oe), .drive_i(pc_drv),
    .pin_o(pc_pin));
  pio_pin_model pg_load (.out_i(pg_out), .oe_i(pg_oe), .drive_i(pg_drv),
    .pin_o(pg_pin));

  task automatic chk(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    got = rdata_o;
  endtask : bus_rd

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
  endtask : do_reset

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    do_reset();
    chk("pc_oe reset", pc_oe, 8'h00);
    chk("pd_oe reset", {2'b00, pd_oe}, 8'h00);
    chk("pg_oe reset", pg_oe, 8'h00);
    chk("pa_oe reset", pa_oe, 8'h70);
    chk("stbb idle", {7'h00, strobe_b_o}, 8'h01);
    bus_rd(16'h1007);
    chk("dirc reset", got, 8'h00);
    bus_rd(16'h1009);
    chk("dird reset", got, 8'h00);
    bus_rd(16'h1037);
    chk("dirg reset", got, 8'h00);
    $display("Reset test done");
    foreach (rows[i])
    begin
      bus_wr(rows[i].a, rows[i].d);
      bus_rd(rows[i].a);
      chk("row read", got, rows[i].e);
    end
    chk("pc_out", pc_out, 8'h3C);
    chk("pg_out", pg_out, 8'hA5);
    chk("pd_oe", {2'b00, pd_oe}, 8'h3F);
    chk("pa_oe dir", pa_oe, 8'hF8);
    @(posedge clk_i);
    oc_en <= 8'h08;
    oc_val <= 8'h08;
    bus_wr(16'h1026, 8'h00);
    chk("pin3 override", {6'h00, pa_oe[3], pa_out[3]}, 8'h03);
    $display("Register table test done");
    bus_wr(16'h1004, 8'h81);
    chk("pb_out", pb_out, 8'h81);
    chk("stbb c1", {7'h00, strobe_b_o}, 8'h00);
    @(posedge clk_i);
    #1;
    chk("stbb c2", {7'h00, strobe_b_o}, 8'h00);
    @(posedge clk_i);
    #1;
    chk("stbb c3", {7'h00, strobe_b_o}, 8'h01);
    bus_wr(16'h1005, 8'hC3);
    chk("latch wr pins", pc_out, 8'hC3);
    bus_wr(16'h1007, 8'h00);
    @(posedge clk_i);
    pc_drv <= 8'h96;
    strobe_a <= 1'b0;
    repeat (5) @(posedge clk_i);
    bus_rd(16'h1002);
    chk("flag set", got & 8'h80, 8'h80);
    bus_rd(16'h1005);
    chk("latch fall", got, 8'h96);
    bus_rd(16'h1002);
    chk("flag clear", got & 8'h80, 8'h00);
    bus_wr(16'h1002, 8'h02);
    @(posedge clk_i);
    pc_drv <= 8'h69;
    strobe_a <= 1'b1;
    repeat (5) @(posedge clk_i);
    bus_rd(16'h1005);
    chk("latch rise", got, 8'h69);
    bus_wr(16'h1002, 8'h03);
    chk("stbb idle inv", {7'h00, strobe_b_o}, 8'h00);
    bus_wr(16'h1004, 8'h24);
    chk("stbb active inv", {7'h00, strobe_b_o}, 8'h01);
    $display("Strobe test done");
    @(posedge clk_i);
    spi_m <= 1'b1;
    ser_en <= 6'h3F;
    bus_wr(16'h1009, 8'h20);
    bus_wr(16'h1008, 8'h20);
    chk("mode fault", {7'h00, mode_fault_en_o}, 8'h00);
    chk("ss gpio", {6'h00, pd_oe[5], pd_out[5]}, 8'h03);
    @(posedge clk_i);
    pe_in <= 8'hA7;
    repeat (3) @(posedge clk_i);
    // Fifth port read only with static inputs
    bus_rd(16'h100A);
    chk("port e", got, 8'hA7);
    $display("Serial and port E test done");
    @(posedge clk_i);
    mode <= PIO_MODE_EXPANDED;
    addr_hi <= 8'h12;
    ext_ad <= 8'h34;
    ext_ad_oe <= 1'b1;
    bus_wr(16'h1003, 8'h55);
    chk("ext access", {7'h00, ext_access_o}, 8'h01);
    chk("pb addr", pb_out, 8'h12);
    chk("pc bus", pc_out, 8'h34);
    chk("pc bus oe", pc_oe, 8'hFF);
    @(posedge clk_i);
    mode <= PIO_MODE_TEST;
    bus_rd(16'h1003);
    chk("pc ext read", got, 8'h00);
    chk("ext read pulse", {7'h00, ext_access_o}, 8'h01);
    @(posedge clk_i);
    mode <= PIO_MODE_BOOT;
    do_reset();
    chk("pc_out rst", pc_out, 8'h00);
    chk("pc_oe rst", pc_oe, 8'h00);
    $display("Mode and reset test done");
    complete_run();
  end
endmodule : tb_top
